// ---- flash_par_pkg.sv ----
`default_nettype none
package flash_par_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: printed figures and the cycle counts derived from them.
   localparam int CLK_PERIOD_NS = 5;
   localparam int RESP_MAX_NS = 5000;
   localparam int READ_MAX_NS = 7000;
   localparam int ID_CMD_MAX_NS = 20000;
   localparam int PREP_MAX_NS = 5000;
   // Longest times round down to whole cycles.
   localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;
   localparam int READ_MAX_CYC = READ_MAX_NS / CLK_PERIOD_NS;
   localparam int ID_CMD_MAX_CYC = ID_CMD_MAX_NS / CLK_PERIOD_NS;
   localparam int PREP_MAX_CYC = PREP_MAX_NS / CLK_PERIOD_NS;
   // Every answer waits this long; far below the tightest limit even with sync latency.
   localparam logic [4:0] RESP_DELAY_CYC = 5'(RESP_MAX_CYC / 64);

   ////////////////////////////////////////////////////////////////////////////
   // Pin bundle through the synchroniser: strobe, framing line, data byte.
   localparam int PIN_WIDTH = 10;
   localparam int STROBE_BIT = 9;
   localparam int FRAME_BIT = 8;
   localparam logic [9:0] PIN_IDLE = 10'h300;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and status codes.
   localparam logic ACK_RST = 1'b1;
   localparam logic RESP_RST = 1'b1;
   localparam logic [3:0] STATUS_LOADING = 4'hf;
   localparam logic [3:0] RESULT_OK = 4'h0;
   localparam logic [3:0] STATUS_BAD_CMD_DEFAULT = 4'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Command words, first byte in the top lane.
   localparam logic [31:0] CMD_READ_ID = 32'h3600_0000;
   localparam logic [31:0] CMD_PREP_READ = 32'h0002_0000;
   localparam logic [2:0] CMD_LEN = 3'h4;
   localparam logic [3:0] ID_FIRST_BYTE = 4'h4;
   localparam logic [3:0] ID_WORD1_BYTE = 4'h8;
   localparam logic [3:0] ID_END_BYTE = 4'hc;

   typedef enum logic [10:0] {
      S_LOAD = 11'h001,
      S_IDLE = 11'h002,
      S_OPEN = 11'h004,
      S_BYTE = 11'h008,
      S_ACKDN = 11'h010,
      S_ACKWT = 11'h020,
      S_ACKUP = 11'h040,
      S_EXEC = 11'h080,
      S_RDN = 11'h100,
      S_RWAIT = 11'h200,
      S_RUP = 11'h400
   } state_e;

endpackage : flash_par_pkg
`default_nettype wire

// ---- byte_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Byte stream with valid and ready between the capture logic and the decoder.
interface byte_stream_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } sync_s;

   sync_s sync_reg;
   sync_s sync_next;

   ////////////////////////////////////////////////////////////////////////////
   // Only stages two and three are compared; stage one feeds stage two alone.
   always_comb begin
      sync_next = sync_reg;
      sync_next.s1 = d;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_reg.s2[i] == sync_reg.s3[i]) begin
            sync_next.q[i] = sync_reg.s3[i];
         end
      end
   end

   // Register the whole synchroniser state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_reg <= {INIT, INIT, INIT, INIT};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg.q;

   // A filtered bit moves only to a value that stages two and three agreed on.
   // Judged lane by lane, since other lanes may still be settling when one moves.
   agree_filter_a: assert property (@(posedge clk) disable iff (!arst_n)
      q != $past(q) |-> ((q ^ $past(q)) & ($past(sync_reg.s2) ^ $past(sync_reg.s3))) == '0)
      else $error("Filtered pin changed without agreement.");

endmodule : pin_sync
`default_nettype wire

// ---- byte_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   byte_stream_if.snk fill,
   byte_stream_if.src drain
);

   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic rd_ptr;
      logic [1:0] count;
   } buf_s;

   buf_s buf_reg;
   buf_s buf_next;
   logic push;
   logic pop;

   // Full refuses the writer, so a stalled reader never costs a byte.
   assign fill.ready = (buf_reg.count != 2'h2);
   assign drain.valid = (buf_reg.count != 2'h0);
   assign drain.data = buf_reg.mem[buf_reg.rd_ptr];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry ring addressed by the read pointer and the fill count.
   always_comb begin
      buf_next = buf_reg;
      if (push) begin
         buf_next.mem[buf_reg.rd_ptr ^ buf_reg.count[0]] = fill.data;
      end
      if (pop) begin
         buf_next.rd_ptr = ~buf_reg.rd_ptr;
      end
      if (push && !pop) begin
         buf_next.count = buf_reg.count + 2'h1;
      end else if (pop && !push) begin
         buf_next.count = buf_reg.count - 2'h1;
      end
   end

   // Register the buffer state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_reg <= '0;
      end else begin
         buf_reg <= buf_next;
      end
   end

   // Never more than two entries held.
   buf_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
      buf_reg.count != 2'h3)
      else $error("Buffer count out of range.");

   // A byte pushed into an empty buffer is offered on the next cycle unchanged.
   buf_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
      push && buf_reg.count == 2'h0 |=> drain.valid && drain.data == $past(fill.data))
      else $error("Buffered byte lost or altered.");

endmodule : byte_buffer
`default_nettype wire

// ---- flash_par_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_par_port #(
   parameter logic [31:0] PART_ID_WORD0 = 32'h5a5a_0101, // Arbitrary value.
   parameter logic [31:0] PART_ID_WORD1 = 32'h0000_0000, // Arbitrary value.
   parameter logic ID_TWO_WORDS = 1'b0,
   parameter logic [3:0] STATUS_BAD_CMD = flash_par_pkg::STATUS_BAD_CMD_DEFAULT
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic loader_done,
   input wire logic programmer_strobe_n,
   input wire logic cmd_frame_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic device_ack_n,
   output logic response_flag,
   output logic [3:0] status_lines,
   output logic parallel_mode
);

   localparam int RESP_BOUND = 40;
   localparam int STEADY_BOUND = 2;

   typedef struct packed {
      flash_par_pkg::state_e st;
      logic [4:0] cnt;
      logic ack;
      logic res;
      logic [3:0] status;
      logic [7:0] dout;
      logic oe;
      logic par;
      logic [31:0] cmd_word;
      logic [2:0] nbytes;
      logic id_armed;
      logic rd_ok;
      logic [3:0] rd_idx;
   } core_s;

   core_s core_reg;
   core_s core_next;
   logic [9:0] pins_sync;
   logic s_strobe;
   logic s_frame;
   logic [7:0] s_data;

   byte_stream_if cmd_in ();
   byte_stream_if cmd_out ();

   ////////////////////////////////////////////////////////////////////////////
   // Strobe, frame and data share one filter so data lags no less than the strobe.
   // three-stage filtering
   pin_sync #(
      .WIDTH(flash_par_pkg::PIN_WIDTH),
      .INIT(flash_par_pkg::PIN_IDLE)
   ) u_pin_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d({programmer_strobe_n, cmd_frame_n, data_in}),
      .q(pins_sync)
   );

   assign s_strobe = pins_sync[flash_par_pkg::STROBE_BIT];
   assign s_frame = pins_sync[flash_par_pkg::FRAME_BIT];
   assign s_data = pins_sync[7:0];

   // Captured command bytes wait here; a full buffer holds the acknowledge back.
   byte_buffer #(
      .WIDTH(8)
   ) u_byte_buffer (
      .clk(clk),
      .arst_n(arst_n),
      .fill(cmd_in.snk),
      .drain(cmd_out.src)
   );

   assign cmd_in.valid = (core_reg.st == flash_par_pkg::S_BYTE) && !s_frame && !s_strobe;
   assign cmd_in.data = s_data;
   // Decoder stalls only in the cycle that judges the finished command.
   assign cmd_out.ready = (core_reg.st != flash_par_pkg::S_EXEC) || (core_reg.cnt != 5'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Byte shown at a read position: filler, then identifier bytes low first.
   // filler then identifier bytes
   function automatic logic [7:0] read_byte(input logic [3:0] idx, input logic ok);
      logic [63:0] idw;
      logic [3:0] off;
      idw = {PART_ID_WORD1, PART_ID_WORD0};
      off = idx - flash_par_pkg::ID_FIRST_BYTE;
      read_byte = 8'h00;
      if (ok && idx >= flash_par_pkg::ID_FIRST_BYTE && idx < flash_par_pkg::ID_END_BYTE) begin
         if (ID_TWO_WORDS || idx < flash_par_pkg::ID_WORD1_BYTE) begin
            read_byte = idw[{off[2:0], 3'h0} +: 8];
         end
      end
   endfunction : read_byte

   ////////////////////////////////////////////////////////////////////////////
   // Handshake sequencer, command decoder and read source.
   always_comb begin
      core_next = core_reg;
      // bytes of a cycle counted from one
      if (cmd_out.valid && cmd_out.ready) begin
         core_next.cmd_word = {core_reg.cmd_word[23:0], cmd_out.data};
         if (core_reg.nbytes != 3'h7) begin
            core_next.nbytes = core_reg.nbytes + 3'h1;
         end
      end
      case (core_reg.st)
         flash_par_pkg::S_LOAD: begin
            // confirm load by dropping status and response
            if (loader_done) begin
               core_next.status = flash_par_pkg::RESULT_OK;
               core_next.res = 1'b0;
               core_next.par = 1'b1;
               core_next.st = flash_par_pkg::S_IDLE;
            end
         end
         flash_par_pkg::S_IDLE: begin
            // act only on a programmer edge
            if (!s_frame) begin
               core_next.cnt = flash_par_pkg::RESP_DELAY_CYC;
               core_next.nbytes = 3'h0;
               core_next.cmd_word = 32'h0000_0000;
               core_next.st = flash_par_pkg::S_OPEN;
            end else if (!s_strobe) begin
               core_next.dout = read_byte(core_reg.rd_idx, core_reg.rd_ok);
               core_next.oe = 1'b1;
               core_next.cnt = flash_par_pkg::RESP_DELAY_CYC;
               if (core_reg.rd_idx != 4'hf) begin
                  core_next.rd_idx = core_reg.rd_idx + 4'h1;
               end
               core_next.st = flash_par_pkg::S_RDN;
            end
         end
         flash_par_pkg::S_OPEN: begin
            if (core_reg.cnt == 5'h0) begin
               core_next.res = 1'b1;
               core_next.st = flash_par_pkg::S_BYTE;
            end else begin
               core_next.cnt = core_reg.cnt - 5'h1;
            end
         end
         flash_par_pkg::S_BYTE: begin
            if (s_frame) begin
               core_next.cnt = flash_par_pkg::RESP_DELAY_CYC;
               core_next.st = flash_par_pkg::S_EXEC;
            end else if (!s_strobe && cmd_in.ready) begin
               core_next.cnt = flash_par_pkg::RESP_DELAY_CYC;
               core_next.st = flash_par_pkg::S_ACKDN;
            end
         end
         flash_par_pkg::S_ACKDN: begin
            if (core_reg.cnt == 5'h0) begin
               core_next.ack = 1'b0;
               core_next.st = flash_par_pkg::S_ACKWT;
            end else begin
               core_next.cnt = core_reg.cnt - 5'h1;
            end
         end
         flash_par_pkg::S_ACKWT: begin
            if (s_strobe) begin
               core_next.cnt = flash_par_pkg::RESP_DELAY_CYC;
               core_next.st = flash_par_pkg::S_ACKUP;
            end
         end
         flash_par_pkg::S_ACKUP: begin
            if (core_reg.cnt == 5'h0) begin
               core_next.ack = 1'b1;
               core_next.st = flash_par_pkg::S_BYTE;
            end else begin
               core_next.cnt = core_reg.cnt - 5'h1;
            end
         end
         flash_par_pkg::S_EXEC: begin
            if (core_reg.cnt != 5'h0) begin
               core_next.cnt = core_reg.cnt - 5'h1;
            end else begin
               core_next.res = 1'b0;
               core_next.st = flash_par_pkg::S_IDLE;
               if (core_reg.nbytes == flash_par_pkg::CMD_LEN && core_reg.cmd_word == flash_par_pkg::CMD_READ_ID) begin
                  core_next.id_armed = 1'b1;
                  core_next.rd_ok = 1'b0;
                  core_next.status = flash_par_pkg::RESULT_OK;
               end else if (core_reg.nbytes == flash_par_pkg::CMD_LEN &&
                            core_reg.cmd_word == flash_par_pkg::CMD_PREP_READ && core_reg.id_armed) begin
                  core_next.rd_ok = 1'b1;
                  core_next.rd_idx = 4'h0;
                  core_next.id_armed = 1'b0;
                  core_next.status = flash_par_pkg::RESULT_OK;
               end else begin
                  core_next.id_armed = 1'b0;
                  core_next.rd_ok = 1'b0;
                  core_next.status = STATUS_BAD_CMD;
               end
            end
         end
         flash_par_pkg::S_RDN: begin
            // byte on bus before acknowledge falls
            if (core_reg.cnt == 5'h0) begin
               core_next.ack = 1'b0;
               core_next.st = flash_par_pkg::S_RWAIT;
            end else begin
               core_next.cnt = core_reg.cnt - 5'h1;
            end
         end
         flash_par_pkg::S_RWAIT: begin
            if (s_strobe) begin
               core_next.cnt = flash_par_pkg::RESP_DELAY_CYC;
               core_next.st = flash_par_pkg::S_RUP;
            end
         end
         flash_par_pkg::S_RUP: begin
            if (core_reg.cnt == 5'h0) begin
               core_next.ack = 1'b1;
               core_next.oe = 1'b0;
               core_next.st = flash_par_pkg::S_IDLE;
            end else begin
               core_next.cnt = core_reg.cnt - 5'h1;
            end
         end
         default: begin
            core_next.st = flash_par_pkg::S_IDLE;
         end
      endcase
   end

   // Register the core state; loading state shows all status lines high.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_reg <= '{st: flash_par_pkg::S_LOAD, cnt: 5'h0, ack: flash_par_pkg::ACK_RST,
                       res: flash_par_pkg::RESP_RST, status: flash_par_pkg::STATUS_LOADING,
                       dout: 8'h00, oe: 1'b0, par: 1'b0, cmd_word: 32'h0000_0000,
                       nbytes: 3'h0, id_armed: 1'b0, rd_ok: 1'b0, rd_idx: 4'h0};
      end else begin
         core_reg <= core_next;
      end
   end

   // parallel_mode marks the swapped pin functions
   assign parallel_mode = core_reg.par;
   assign device_ack_n = core_reg.ack;
   assign response_flag = core_reg.res;
   assign status_lines = core_reg.status;
   assign data_out = core_reg.dout;
   assign data_oe = core_reg.oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the handshake.
   response_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
      core_reg.st == flash_par_pkg::S_IDLE && !s_frame |-> ##[1:RESP_BOUND] response_flag)
      else $error("Response flag late after frame fell.");

   cmd_ack_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
      cmd_in.valid && cmd_in.ready |-> ##[1:RESP_BOUND] !device_ack_n)
      else $error("Acknowledge late after command strobe.");

   ack_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(s_strobe) && !device_ack_n |-> ##[1:RESP_BOUND] device_ack_n)
      else $error("Acknowledge late after strobe rose.");

   cmd_bus_released_a: assert property (@(posedge clk) disable iff (!arst_n)
      response_flag |-> !data_oe)
      else $error("Data driven during command sequence.");

   read_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
      core_reg.st == flash_par_pkg::S_IDLE && s_frame && !s_strobe
      |=> data_oe ##[0:RESP_BOUND] !device_ack_n && data_oe)
      else $error("Read byte or acknowledge missing.");

   read_steady_a: assert property (@(posedge clk) disable iff (!arst_n)
      core_reg.st == flash_par_pkg::S_RWAIT |-> ##[1:STEADY_BOUND] $stable(response_flag) && $stable(status_lines))
      else $error("Status or response moved during read.");

   id_status_a: assert property (@(posedge clk) disable iff (!arst_n)
      core_reg.st == flash_par_pkg::S_EXEC && core_reg.cnt == 5'h0 &&
      core_reg.nbytes == flash_par_pkg::CMD_LEN && core_reg.cmd_word == flash_par_pkg::CMD_READ_ID
      |=> status_lines == flash_par_pkg::RESULT_OK && !response_flag)
      else $error("Identifier command did not report success.");

   no_initiative_a: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(device_ack_n) |-> !s_strobe)
      else $error("Acknowledge fell without a strobe.");

   id_low_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
      core_reg.st == flash_par_pkg::S_IDLE && s_frame && !s_strobe && core_reg.rd_ok &&
      core_reg.rd_idx == flash_par_pkg::ID_FIRST_BYTE |=> data_out == PART_ID_WORD0[7:0])
      else $error("Identifier low byte not first.");

endmodule : flash_par_port
`default_nettype wire

// ---- programmer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behavioural parallel programmer facing the device port.
module programmer_model (
   input wire logic clk,
   input wire logic device_ack_n,
   input wire logic response_flag,
   input wire logic [7:0] bus_in,
   output logic strobe_n,
   output logic frame_n,
   output logic [7:0] drive_data,
   output logic drive_oe
);
   int slow = 0; // Extra cycles after each answer, so prompt and slow programmers are both exercised.
   initial begin
      strobe_n = 1'b1;
      frame_n = 1'b1;
      drive_data = 8'h00;
      drive_oe = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // bounded answer wait
   // The device never gives up, so every wait here carries its own limit.
   task automatic wait_for(input bit use_ack, input logic lvl, input int lim);
      int n;
      n = 0;
      while (((use_ack ? device_ack_n : response_flag) !== lvl) && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         $display("BAD %0t handshake answer too late", $time);
         tb_top.error_cnt++;
         tb_top.final_report();
      end
      repeat (slow) @(negedge clk);
   endtask : wait_for
   task automatic send_cmd(input logic [31:0] w, input int lim);
      frame_n = 1'b0;
      wait_for(1'b0, 1'b1, flash_par_pkg::RESP_MAX_CYC);
      for (int i = 3; i >= 0; i--) begin
         drive_oe = 1'b1;
         drive_data = w[i*8 +: 8];
         repeat (4) @(negedge clk);
         strobe_n = 1'b0;
         wait_for(1'b1, 1'b0, flash_par_pkg::RESP_MAX_CYC);
         strobe_n = 1'b1;
         wait_for(1'b1, 1'b1, flash_par_pkg::RESP_MAX_CYC);
      end
      frame_n = 1'b1;
      wait_for(1'b0, 1'b0, lim);
      drive_oe = 1'b0;
   endtask : send_cmd
   task automatic read_byte(output logic [7:0] b);
      drive_oe = 1'b0;
      strobe_n = 1'b0;
      wait_for(1'b1, 1'b0, flash_par_pkg::READ_MAX_CYC);
      b = bus_in;
      strobe_n = 1'b1;
      wait_for(1'b1, 1'b1, flash_par_pkg::RESP_MAX_CYC);
   endtask : read_byte
endmodule : programmer_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] ID0 = 32'hc3a5_17e9; // Arbitrary value.
   localparam logic [31:0] ID1 = 32'h1b2d_4f60; // Arbitrary value.
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic loader_done = 1'b0;
   logic strobe_n, frame_n, drive_oe, data_oe, device_ack_n, response_flag, parallel_mode;
   logic [7:0] drive_data, data_out, data_in, dev_bus;
   logic [7:0] idle_pat = 8'h5a;
   logic [3:0] status_lines;
   logic [31:0] cmds [10];
   int error_cnt = 0;
   int checked = 0;
   // Clock at 200 MHz.
   always #2.5 clk = ~clk;
   // A released bus floats, so it shows a pattern that changes every cycle.
   always @(posedge clk) idle_pat <= idle_pat + 8'h35;
   assign dev_bus = data_oe ? data_out : idle_pat;
   assign data_in = drive_oe ? drive_data : dev_bus;
   ////////////////////////////////////////////////////////////////////////////
   flash_par_port #(.PART_ID_WORD0(ID0), .PART_ID_WORD1(ID1), .ID_TWO_WORDS(1'b1)) i_flash_par_port (
      .clk(clk), .arst_n(arst_n), .loader_done(loader_done), .programmer_strobe_n(strobe_n),
      .cmd_frame_n(frame_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .device_ack_n(device_ack_n), .response_flag(response_flag), .status_lines(status_lines),
      .parallel_mode(parallel_mode));
   programmer_model i_programmer_model (
      .clk(clk), .device_ack_n(device_ack_n), .response_flag(response_flag), .bus_in(dev_bus),
      .strobe_n(strobe_n), .frame_n(frame_n), .drive_data(drive_data), .drive_oe(drive_oe));
   ////////////////////////////////////////////////////////////////////////////
   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   // Status expected after a command, given whether the previous one asked for the identifier.
   function automatic logic [3:0] exp_status(input logic [31:0] w, input bit after_id);
      if (w == flash_par_pkg::CMD_READ_ID || (w == flash_par_pkg::CMD_PREP_READ && after_id)) return 4'h0;
      return flash_par_pkg::STATUS_BAD_CMD_DEFAULT;
   endfunction : exp_status
   // Read byte expected at a position counted from one; bytes one to four are filler.
   function automatic logic [7:0] exp_byte(input int idx, input bit prep);
      logic [63:0] id;
      id = {ID1, ID0};
      if (!prep || idx < 5 || idx > 12) return 8'h00;
      return id[(idx-5)*8 +: 8];
   endfunction : exp_byte
   ////////////////////////////////////////////////////////////////////////////
   // The device must never drive the bus while the programmer does.
   always @(negedge clk) begin
      if (drive_oe === 1'b1) check(32'(data_oe), 32'h0);
   end
   // Cuts a hang short well inside the cycle budget.
   initial begin : watchdog
      #400000;
      $display("BAD %0t run did not finish", $time);
      error_cnt++;
      final_report();
   end
   initial begin : main
      bit after_id;
      bit prep;
      int lim;
      logic [7:0] b;
      void'($urandom(11));
      cmds = '{flash_par_pkg::CMD_READ_ID, flash_par_pkg::CMD_PREP_READ, flash_par_pkg::CMD_PREP_READ,
               32'h3600_0001, $urandom(), $urandom(), flash_par_pkg::CMD_READ_ID, 32'h0036_0000,
               flash_par_pkg::CMD_READ_ID, flash_par_pkg::CMD_PREP_READ};
      repeat (10) @(negedge clk);
      check(32'({device_ack_n, response_flag, data_oe, parallel_mode, status_lines}), 32'hcf);
      arst_n = 1'b1;
      @(negedge clk);
      loader_done = 1'b1;
      @(negedge clk);
      loader_done = 1'b0;
      repeat (4) @(negedge clk);
      check(32'({response_flag, parallel_mode, status_lines}), 32'h10);
      after_id = 1'b0;
      for (int t = 0; t < 10; t++) begin
         i_programmer_model.slow = $urandom_range(0, 12);
         lim = (cmds[t] == flash_par_pkg::CMD_PREP_READ) ? flash_par_pkg::PREP_MAX_CYC : flash_par_pkg::ID_CMD_MAX_CYC;
         i_programmer_model.send_cmd(cmds[t], lim);
         check(32'(status_lines), 32'(exp_status(cmds[t], after_id)));
         if (cmds[t] != flash_par_pkg::CMD_READ_ID) begin
            prep = (exp_status(cmds[t], after_id) == 4'h0);
            for (int i = 1; i <= (prep ? 13 : 3); i++) begin
               i_programmer_model.read_byte(b);
               check(32'(b), 32'(exp_byte(i, prep)));
               check(32'({response_flag, status_lines}), 32'({1'b0, exp_status(cmds[t], after_id)}));
            end
         end
         after_id = (cmds[t] == flash_par_pkg::CMD_READ_ID);
         $display("Test %0d done, command %h", t, cmds[t]);
      end
      final_report();
   end
endmodule : tb_top
`default_nettype wire
